// File: hw/usas_defs.svh
// constants of the serial transceiver block
`ifndef USAS_DEFS_SVH
`define USAS_DEFS_SVH
// data length codes
`define USAS_LEN7       2'h0
`define USAS_LEN8       2'h1
`define USAS_LEN9       2'h2
// parity codes
`define USAS_PAR_NONE   2'h0
`define USAS_PAR_EVEN   2'h2
`define USAS_PAR_ODD    2'h3
// oversampling points within one async bit
`define USAS_OVS_LAST   4'hf
`define USAS_VOTE_A     4'h7
`define USAS_VOTE_B     4'h8
`define USAS_VOTE_C     4'h9
// rate ceilings and derived least cycle counts
`define USAS_CLK_HZ     40000000
`define USAS_ASYNC_BPS  1875000
`define USAS_SYNC_BPS   10000000
`define USAS_ASYNC_BIT_CYC ((`USAS_CLK_HZ + `USAS_ASYNC_BPS - 1) / `USAS_ASYNC_BPS)
`define USAS_SYNC_BIT_CYC  ((`USAS_CLK_HZ + `USAS_SYNC_BPS - 1) / `USAS_SYNC_BPS)
// least reload keeps ticks two cycles apart at the highest rates
`define USAS_MIN_RELOAD 16'h0001
// reset value and frame width
`define USAS_BRG_RST    16'h0000
`define USAS_FRAME_W    13
`endif

// File: hw/usas_pkg.sv
// types of the serial transceiver block
package usas_pkg;
  // transmitter states
  typedef enum logic [0:0] {USAS_TX_IDLE = 1'b0, USAS_TX_SHIFT = 1'b1} usas_tx_state_type;
  // receiver states
  typedef enum logic [0:0] {USAS_RX_IDLE = 1'b0, USAS_RX_BITS = 1'b1} usas_rx_state_type;
  // configuration and control bits
  typedef struct packed {
    logic        enable;
    logic [1:0]  dataLen;
    logic        stopTwo;
    logic [1:0]  parity;
    logic        syncEn;
    logic        syncMaster;
    logic        samplePhase;
    logic        contClk;
    logic        addrMode;
    logic        ctsEn;
    logic        txDisable;
    logic        txBreak;
    logic        loopData;
    logic        loopFlow;
    logic [15:0] brgReload;
  } usas_cfg_type;
  // one-cycle event pulses
  typedef struct packed {
    logic frameErr;
    logic parErr;
    logic overrun;
    logic underrun;
    logic deltaCts;
    logic deltaBrk;
    logic noise;
  } usas_evt_type;
  // received character with its status
  typedef struct packed {
    logic       noise;
    logic       parErr;
    logic       frameErr;
    logic       isAddr;
    logic [8:0] data;
  } usas_rxword_type;
endpackage

// File: hw/usas_baud_gen.sv
// per-instance baud generator fed by the shared fractional divider
`timescale 1ns/1ps
`include "usas_defs.svh"
module usas_baud_gen #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // divider input and reload
  input  wire logic         fracTick,
  input  wire logic [W-1:0] reload,
  // oversample tick
  output logic              tick
);
  logic [W-1:0] cnt_ff;     // down counter
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] rel;        // clamped reload
  logic         nxt_tick;
  logic         tick_ff;

  assign rel = (reload < W'(`USAS_MIN_RELOAD)) ? W'(`USAS_MIN_RELOAD) : reload;
  assign tick = tick_ff;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (fracTick) begin
      if (cnt_ff == '0) begin
        nxt_cnt  = rel;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - W'(1);
      end
    end
  end

  // register counter and tick
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= W'(`USAS_BRG_RST);
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule // usas_baud_gen

// File: hw/usas_top.sv
// serial transceiver: async and sync transmitter and receiver
`timescale 1ns/1ps
`include "usas_defs.svh"
module usas_top (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // configuration and shared divider tick
  input  wire usas_pkg::usas_cfg_type   cfg,
  input  wire logic                     fracTick,
  // transmit holding buffer
  input  wire logic [8:0]               txData,
  input  wire logic                     txLoad,
  output logic                          txRdy,
  // receive buffer and status
  output usas_pkg::usas_rxword_type     rxWord,
  output logic                          rxRdy,
  input  wire logic                     rxTake,
  output logic                          rxIdle,
  output logic                          rxBreak,
  // event pulses
  output usas_pkg::usas_evt_type        evt,
  // serial pins
  output logic                          txd,
  input  wire logic                     rxdPin,
  output logic                          rtsN,
  input  wire logic                     ctsNPin,
  input  wire logic                     sclkIn,
  output logic                          sclkOut,
  output logic                          sclkOe
);
  // number of data bits
  function automatic logic [3:0] dataBits(input usas_pkg::usas_cfg_type c);
    return (c.dataLen == `USAS_LEN7) ? 4'h7 : (c.dataLen == `USAS_LEN8) ? 4'h8 : 4'h9;
  endfunction
  // bits in a whole character
  function automatic logic [3:0] frameLen(input usas_pkg::usas_cfg_type c);
    return 4'h1 + dataBits(c) + {3'h0, c.parity != `USAS_PAR_NONE} + (c.stopTwo ? 4'h2 : 4'h1);
  endfunction
  // parity bit for the active data bits
  function automatic logic parBit(input usas_pkg::usas_cfg_type c, input logic [8:0] d);
    logic [8:0] m;
    m = 9'h1ff >> (4'h9 - dataBits(c));
    return (^(d & m)) ^ (c.parity == `USAS_PAR_ODD);
  endfunction

  // input synchronisers: rxd, cts, sclk
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  logic       sclkPrev_ff;   // previous sync clock level
  logic       ctsPrev_ff;    // previous cts level
  logic       brgTick;       // oversample tick
  logic       rxLine;        // receive line after loopback
  logic       ctsN;          // cts after loopback
  logic       sclkSrc;       // sync clock seen by the shifters
  logic       sampleEdge;    // sync receive edge
  logic       shiftEdge;     // sync transmit edge
  logic       canSend;       // flow control grant

  usas_baud_gen #(.W(16)) u_brg (
    .clk      (clk),
    .rst      (rst),
    .fracTick (fracTick),
    .reload   (cfg.brgReload),
    .tick     (brgTick)
  );

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_ff <= 3'h7;
      syncB_ff <= 3'h7;
    end else begin
      syncA_ff <= {sclkIn, ctsNPin, rxdPin};
      syncB_ff <= syncA_ff;
    end
  end

  // transmitter state
  usas_pkg::usas_tx_state_type txSt_ff, nxt_txSt;
  logic [8:0]  txBuf_ff, nxt_txBuf;     // single holding entry
  logic        txFull_ff, nxt_txFull;
  logic [12:0] txSh_ff, nxt_txSh;       // remaining frame bits
  logic [3:0]  txCnt_ff, nxt_txCnt;     // bits still to send
  logic [3:0]  txOvs_ff, nxt_txOvs;     // async bit timer
  logic        txd_ff, nxt_txd;
  logic        txLine;                  // line before break forcing
  logic        txStep;                  // bit boundary
  logic [12:0] frame;
  logic        underrun;

  // receiver state
  usas_pkg::usas_rx_state_type rxSt_ff, nxt_rxSt;
  usas_pkg::usas_rxword_type   rxWord_ff, nxt_rxWord;
  logic [12:0] rxSh_ff, nxt_rxSh;       // captured frame bits
  logic [3:0]  rxIdx_ff, nxt_rxIdx;     // next bit position
  logic [3:0]  rxOvs_ff, nxt_rxOvs;     // async sample counter
  logic [1:0]  rxVote_ff, nxt_rxVote;   // first two samples
  logic        rxNoise_ff, nxt_rxNoise; // noise within the character
  logic        rxRdy_ff, nxt_rxRdy;
  logic        rxBrk_ff, nxt_rxBrk;
  logic        bitStb, bitVal, bitNoise;
  logic [3:0]  nBits, len;
  logic [8:0]  dat;

  // misc state: sclk, rts, events
  logic                    sclkOut_ff, nxt_sclkOut;
  logic                    rtsN_ff, nxt_rtsN;
  usas_pkg::usas_evt_type  evt_ff, nxt_evt;
  logic                    sclkRun;

  assign rxLine  = cfg.loopData ? txd_ff : syncB_ff[0];
  assign ctsN    = cfg.loopFlow ? rtsN_ff : syncB_ff[1];
  assign sclkSrc = cfg.syncMaster ? sclkOut_ff : syncB_ff[2];
  assign sampleEdge = cfg.syncEn && (cfg.samplePhase ? (sclkPrev_ff && !sclkSrc) : (!sclkPrev_ff && sclkSrc));
  assign shiftEdge  = cfg.syncEn && (cfg.samplePhase ? (!sclkPrev_ff && sclkSrc) : (sclkPrev_ff && !sclkSrc));
  assign canSend = !cfg.txDisable && (!cfg.ctsEn || !ctsN);
  assign nBits   = dataBits(cfg);
  assign len     = frameLen(cfg);

  // transmitter next state
  always_comb begin
    nxt_txSt   = txSt_ff;
    nxt_txBuf  = txBuf_ff;
    nxt_txFull = txFull_ff;
    nxt_txSh   = txSh_ff;
    nxt_txCnt  = txCnt_ff;
    nxt_txOvs  = brgTick ? txOvs_ff + 4'h1 : txOvs_ff;
    txLine     = txd_ff | cfg.txBreak;
    underrun   = 1'b0;
    txStep     = cfg.syncEn ? shiftEdge : (brgTick && txOvs_ff == `USAS_OVS_LAST);
    // start, data lsb first, parity, stops
    frame      = '1;
    frame[0]   = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nBits) frame[i + 1] = txBuf_ff[i];
    end
    if (cfg.parity != `USAS_PAR_NONE) frame[nBits + 4'h1] = parBit(cfg, txBuf_ff);
    // one holding entry, load refused while full
    if (txLoad && !txFull_ff) begin
      nxt_txBuf  = txData;
      nxt_txFull = 1'b1;
    end
    unique case (txSt_ff)
      usas_pkg::USAS_TX_IDLE: begin
        txLine = 1'b1;
        if (cfg.enable && txFull_ff && canSend && txStep) begin
          txLine     = frame[0];
          nxt_txSh   = frame >> 1;
          nxt_txCnt  = len - 4'h1;
          nxt_txFull = 1'b0;
          nxt_txSt   = usas_pkg::USAS_TX_SHIFT;
        end else if (cfg.syncEn && !cfg.syncMaster && shiftEdge && !txFull_ff) begin
          // slave clocked with nothing to send
          underrun = 1'b1;
        end
      end
      usas_pkg::USAS_TX_SHIFT: begin
        if (txStep) begin
          if (txCnt_ff == 4'h0) begin
            txLine   = 1'b1;
            nxt_txSt = usas_pkg::USAS_TX_IDLE;
          end else begin
            txLine    = txSh_ff[0];
            nxt_txSh  = txSh_ff >> 1;
            nxt_txCnt = txCnt_ff - 4'h1;
          end
        end
      end
    endcase
    nxt_txd = txLine && !cfg.txBreak;
  end

  // receiver next state
  always_comb begin
    nxt_rxSt    = rxSt_ff;
    nxt_rxWord  = rxWord_ff;
    nxt_rxSh    = rxSh_ff;
    nxt_rxIdx   = rxIdx_ff;
    nxt_rxOvs   = brgTick ? rxOvs_ff + 4'h1 : rxOvs_ff;
    nxt_rxVote  = rxVote_ff;
    nxt_rxNoise = rxNoise_ff;
    nxt_rxRdy   = rxRdy_ff && !rxTake;
    nxt_rxBrk   = rxBrk_ff;
    bitStb      = 1'b0;
    bitVal      = rxLine;
    bitNoise    = 1'b0;
    dat         = '0;
    nxt_evt     = '0;
    if (!cfg.syncEn && brgTick && rxSt_ff == usas_pkg::USAS_RX_BITS) begin
      if (rxOvs_ff == `USAS_VOTE_A) nxt_rxVote[0] = rxLine;
      if (rxOvs_ff == `USAS_VOTE_B) nxt_rxVote[1] = rxLine;
      if (rxOvs_ff == `USAS_VOTE_C) begin
        bitStb   = 1'b1;
        bitVal   = (rxVote_ff[0] & rxVote_ff[1]) | (rxLine & (rxVote_ff[0] | rxVote_ff[1]));
        bitNoise = !((rxVote_ff[0] == rxVote_ff[1]) && (rxVote_ff[1] == rxLine));
      end
    end else if (cfg.syncEn && sampleEdge && rxSt_ff == usas_pkg::USAS_RX_BITS) begin
      bitStb = 1'b1;
    end
    nxt_evt.noise = bitNoise;
    unique case (rxSt_ff)
      usas_pkg::USAS_RX_IDLE: begin
        // break ends when line returns high
        if (rxBrk_ff && rxLine) begin
          nxt_rxBrk        = 1'b0;
          nxt_evt.deltaBrk = 1'b1;
        end else if (cfg.enable && !rxBrk_ff && !rxLine && (cfg.syncEn ? sampleEdge : brgTick)) begin
          nxt_rxSt    = usas_pkg::USAS_RX_BITS;
          nxt_rxOvs   = 4'h1;
          nxt_rxIdx   = cfg.syncEn ? 4'h1 : 4'h0;
          nxt_rxSh    = '0;
          nxt_rxNoise = 1'b0;
        end
      end
      usas_pkg::USAS_RX_BITS: begin
        if (bitStb) begin
          nxt_rxSh[rxIdx_ff] = bitVal;
          nxt_rxNoise        = rxNoise_ff | bitNoise;
          nxt_rxIdx          = rxIdx_ff + 4'h1;
          if (rxIdx_ff == 4'h0 && bitVal) begin
            // false start in async mode
            nxt_rxSt = usas_pkg::USAS_RX_IDLE;
          end else if (rxIdx_ff == len - 4'h1) begin
            nxt_rxSt = usas_pkg::USAS_RX_IDLE;
            for (int i = 0; i < 9; i++) begin
              if (4'(i) < nBits) dat[i] = nxt_rxSh[i + 1];
            end
            if (nxt_rxSh == '0) begin
              // all-low character is a break, not data
              nxt_rxBrk        = 1'b1;
              nxt_evt.deltaBrk = !rxBrk_ff;
              nxt_evt.frameErr = 1'b1;
            end else if (rxRdy_ff && !rxTake) begin
              // full buffer keeps the older character
              nxt_evt.overrun = 1'b1;
            end else begin
              // data with its status in one word
              nxt_rxWord.data     = dat;
              nxt_rxWord.noise    = rxNoise_ff | bitNoise;
              nxt_rxWord.frameErr = !nxt_rxSh[len - 4'h1] || (cfg.stopTwo && !nxt_rxSh[len - 4'h2]);
              nxt_rxWord.parErr   = (cfg.parity != `USAS_PAR_NONE) && (nxt_rxSh[nBits + 4'h1] != parBit(cfg, dat));
              nxt_rxWord.isAddr   = cfg.addrMode && (cfg.dataLen == `USAS_LEN9) && dat[8];
              nxt_rxRdy           = 1'b1;
              nxt_evt.frameErr    = nxt_rxWord.frameErr;
              nxt_evt.parErr      = nxt_rxWord.parErr;
            end
          end
        end
      end
    endcase
    nxt_evt.deltaCts = ctsN != ctsPrev_ff;
    nxt_evt.underrun = underrun;
  end

  // sync clock and rts next state
  always_comb begin
    // master clock runs while busy or continuous
    sclkRun     = cfg.enable && cfg.syncEn && cfg.syncMaster &&
                  (txSt_ff == usas_pkg::USAS_TX_SHIFT || (txFull_ff && canSend) || cfg.contClk);
    nxt_sclkOut = sclkOut_ff;
    // stop only at the low idle level
    if (brgTick && (sclkRun || sclkOut_ff)) nxt_sclkOut = !sclkOut_ff;
    // rts high while the receive buffer is full and ctsEn is set
    nxt_rtsN    = cfg.ctsEn && nxt_rxRdy;
  end

  // register all groups
  always_ff @(posedge clk) begin
    if (rst) begin
      txSt_ff     <= usas_pkg::USAS_TX_IDLE;
      txBuf_ff    <= '0;
      txFull_ff   <= 1'b0;
      txSh_ff     <= '1;
      txCnt_ff    <= 4'h0;
      txOvs_ff    <= 4'h0;
      txd_ff      <= 1'b1;
      rxSt_ff     <= usas_pkg::USAS_RX_IDLE;
      rxWord_ff   <= '0;
      rxSh_ff     <= '0;
      rxIdx_ff    <= 4'h0;
      rxOvs_ff    <= 4'h0;
      rxVote_ff   <= 2'h3;
      rxNoise_ff  <= 1'b0;
      rxRdy_ff    <= 1'b0;
      rxBrk_ff    <= 1'b0;
      sclkOut_ff  <= 1'b0;
      sclkPrev_ff <= 1'b0;
      ctsPrev_ff  <= 1'b1;
      rtsN_ff     <= 1'b0;
      evt_ff      <= '0;
    end else begin
      txSt_ff     <= nxt_txSt;
      txBuf_ff    <= nxt_txBuf;
      txFull_ff   <= nxt_txFull;
      txSh_ff     <= nxt_txSh;
      txCnt_ff    <= nxt_txCnt;
      txOvs_ff    <= nxt_txOvs;
      txd_ff      <= nxt_txd;
      rxSt_ff     <= nxt_rxSt;
      rxWord_ff   <= nxt_rxWord;
      rxSh_ff     <= nxt_rxSh;
      rxIdx_ff    <= nxt_rxIdx;
      rxOvs_ff    <= nxt_rxOvs;
      rxVote_ff   <= nxt_rxVote;
      rxNoise_ff  <= nxt_rxNoise;
      rxRdy_ff    <= nxt_rxRdy;
      rxBrk_ff    <= nxt_rxBrk;
      sclkOut_ff  <= nxt_sclkOut;
      sclkPrev_ff <= sclkSrc;
      ctsPrev_ff  <= ctsN;
      rtsN_ff     <= nxt_rtsN;
      evt_ff      <= nxt_evt;
    end
  end

  // outputs
  // event requests to the system
  assign evt     = evt_ff;
  assign txRdy   = !txFull_ff;
  assign rxWord  = rxWord_ff;
  assign rxRdy   = rxRdy_ff;
  assign rxIdle  = (rxSt_ff == usas_pkg::USAS_RX_IDLE) && !rxBrk_ff;
  assign rxBreak = rxBrk_ff;
  assign txd     = txd_ff;
  assign rtsN    = rtsN_ff;
  assign sclkOut = sclkOut_ff;
  assign sclkOe  = cfg.syncEn && cfg.syncMaster;
endmodule // usas_top

// File: verif/usas_top_asserts.sv
// port checker for the serial transceiver
`timescale 1ns/1ps
`include "usas_defs.svh"
module usas_top_asserts (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // configuration and buffers
  input wire usas_pkg::usas_cfg_type    cfg,
  input wire logic                      txLoad,
  input wire logic                      txRdy,
  input wire usas_pkg::usas_rxword_type rxWord,
  input wire logic                      rxRdy,
  input wire logic                      rxIdle,
  input wire logic                      rxBreak,
  input wire usas_pkg::usas_evt_type    evt,
  // serial pins
  input wire logic                      txd,
  input wire logic                      rtsN,
  input wire logic                      ctsNPin,
  input wire logic                      sclkOut,
  input wire logic                      sclkOe
);
  // one clock domain; reset silences every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shifter takes the held character; first edge after reset excluded
  sequence s_start;
    $rose(txRdy) && !$past(rst);
  endsequence
  // synchroniser lag makes the window several cycles wide
  sequence s_ctsMove;
    $changed(ctsNPin) && !cfg.loopFlow && !$past(rst);
  endsequence
  property p_load; txLoad && txRdy |=> !txRdy; endproperty
  a_load: assert property (p_load) else $error("holding buffer not marked full");
  property p_start; s_start |-> !txd; endproperty
  a_start: assert property (p_start) else $error("frame began without a low start bit");
  property p_txDis; s_start |-> !$past(cfg.txDisable); endproperty
  a_txDis: assert property (p_txDis) else $error("frame began while transmit disabled");
  property p_cts;
    s_start ##0 (cfg.ctsEn && !cfg.loopFlow) |->
      !$past(ctsNPin, 2) || !$past(ctsNPin, 3) || !$past(ctsNPin, 4) || !$past(ctsNPin, 5);
  endproperty
  a_cts: assert property (p_cts) else $error("frame began without clear to send");
  property p_dCts; s_ctsMove |-> ##[1:5] evt.deltaCts; endproperty
  a_dCts: assert property (p_dCts) else $error("clear to send change not flagged");
  property p_brk; cfg.txBreak |=> !txd; endproperty
  a_brk: assert property (p_brk) else $error("break not driven on txd");
  property p_dBrk; $changed(rxBreak) && !$past(rst) |-> ($past(evt.deltaBrk) or ##[0:1] evt.deltaBrk); endproperty
  a_dBrk: assert property (p_dBrk) else $error("break change not flagged");
  property p_brkIdle; rxBreak |-> !rxIdle; endproperty
  a_brkIdle: assert property (p_brkIdle) else $error("idle reported during break");
  property p_oe; sclkOe == (cfg.syncEn && cfg.syncMaster); endproperty
  a_oe: assert property (p_oe) else $error("sync clock enable wrong for mode");
  property p_sclk; (!cfg.syncEn)[*3] |-> !sclkOut; endproperty
  a_sclk: assert property (p_sclk) else $error("sync clock moves in async mode");
  property p_rtsFull; (cfg.ctsEn && rxRdy)[*2] |-> rtsN; endproperty
  a_rtsFull: assert property (p_rtsFull) else $error("rts asserted with buffer full");
  property p_rtsFree; (!cfg.ctsEn)[*2] |-> !rtsN; endproperty
  a_rtsFree: assert property (p_rtsFree) else $error("rts withdrawn without flow control");
  property p_ovr; evt.overrun |-> rxRdy; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun with empty buffer");
  property p_addr; rxRdy && rxWord.isAddr |-> rxWord.data[8] && cfg.addrMode; endproperty
  a_addr: assert property (p_addr) else $error("address mark without ninth bit");
endmodule // usas_top_asserts

bind usas_top usas_top_asserts chk_u (.clk(clk), .rst(rst), .cfg(cfg), .txLoad(txLoad), .txRdy(txRdy),
  .rxWord(rxWord), .rxRdy(rxRdy), .rxIdle(rxIdle), .rxBreak(rxBreak), .evt(evt), .txd(txd), .rtsN(rtsN),
  .ctsNPin(ctsNPin), .sclkOut(sclkOut), .sclkOe(sclkOe));

// File: verif/usas_remote.sv
// remote serial transceiver model at the far end of the link
`timescale 1ns/1ps
module usas_remote #(
  parameter int BITCYC = 32  // clock cycles per serial bit
) (
  // clock
  input wire logic clk,
  // lines seen from the far end
  input wire logic txd,
  output logic     rxd,
  output logic     ctsN
);
  // line idles high, sending allowed
  initial begin
    rxd = 1'b1;
    ctsN = 1'b0;
  end
  // hold one bit for a full bit time
  task automatic bitOut(input logic b);
    rxd = b;
    repeat (BITCYC) @(negedge clk);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] par, input logic two,
                      input logic bad);
    logic p;
    p = par[0] ^ bad;
    bitOut(1'b0);
    for (int i = 0; i < nb; i++) begin
      bitOut(d[i]);
      p ^= d[i];
    end
    if (par[1]) bitOut(p);
    bitOut(1'b1);
    if (two) bitOut(1'b1);
  endtask
  // line held low past a frame
  task automatic sendBreak(input int nbits);
    rxd = 1'b0;
    repeat (nbits * BITCYC) @(negedge clk);
    rxd = 1'b1;
  endtask
  // clear to send, active low
  task automatic setCts(input logic v);
    ctsN = v;
  endtask
  task automatic recv(output logic [8:0] d, output logic pb, output logic [1:0] st, output bit ok,
                      input int nb, input logic hasPar, input logic two);
    ok = 1'b0;
    d = '0;
    pb = 1'b0;
    st = 2'h0;
    for (int k = 0; k < 4000 && txd; k++) @(negedge clk);
    if (txd) return;
    repeat (BITCYC / 2) @(negedge clk);
    ok = !txd;
    for (int i = 0; i < nb; i++) begin
      repeat (BITCYC) @(negedge clk);
      d[i] = txd;
    end
    if (hasPar) begin
      repeat (BITCYC) @(negedge clk);
      pb = txd;
    end
    repeat (BITCYC) @(negedge clk);
    st = {1'b1, txd};
    if (two) begin
      repeat (BITCYC) @(negedge clk);
      st[1] = txd;
    end
  endtask
endmodule // usas_remote

// File: verif/usas_top_tb.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`include "usas_defs.svh"
module usas_top_tb;
  // reload 1 with the divider tick always high gives 2-cycle ticks, 16 per bit
  localparam int BITCYC = 32;
  localparam logic [1:0] PARTAB [3] = '{`USAS_PAR_NONE, `USAS_PAR_EVEN, `USAS_PAR_ODD};
  // design inputs
  logic                      clk, rst, fracTick, txLoad, rxTake, sclkIn;
  logic [8:0]                txData;
  usas_pkg::usas_cfg_type    cfg;
  // design outputs and far-end lines
  logic                      txRdy, rxRdy, rxIdle, rxBreak, txd, rxdPin, rtsN, ctsNPin, sclkOut, sclkOe;
  usas_pkg::usas_rxword_type rxWord;
  usas_pkg::usas_evt_type    evt, evtSeen;
  // counters and scratch
  int                        badCount, nChecks;
  logic [8:0]                d0, d1;
  usas_top dut_u (.clk(clk), .rst(rst), .cfg(cfg), .fracTick(fracTick), .txData(txData), .txLoad(txLoad),
    .txRdy(txRdy), .rxWord(rxWord), .rxRdy(rxRdy), .rxTake(rxTake), .rxIdle(rxIdle), .rxBreak(rxBreak),
    .evt(evt), .txd(txd), .rxdPin(rxdPin), .rtsN(rtsN), .ctsNPin(ctsNPin), .sclkIn(sclkIn),
    .sclkOut(sclkOut), .sclkOe(sclkOe));
  usas_remote #(.BITCYC(BITCYC)) far_u (.clk(clk), .txd(txd), .rxd(rxdPin), .ctsN(ctsNPin));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // sticky copy of one-cycle pulses; the sequence clears it
  always @(posedge clk) evtSeen <= evtSeen | evt;
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait; running out ends the run
  task automatic waitHi(input string what, ref logic s);
    for (int k = 0; k < 4000 && s !== 1'b1; k++) @(negedge clk);
    if (s !== 1'b1) begin
      chk(what, 9'h1, 9'(s));
      endOfTest();
    end
  endtask
  // one load into the holding buffer once it is free
  task automatic load(input logic [8:0] d);
    waitHi("txRdy", txRdy);
    txData = d;
    txLoad = 1'b1;
    @(negedge clk);
    txLoad = 1'b0;
  endtask
  task automatic take();
    rxTake = 1'b1;
    @(negedge clk);
    rxTake = 1'b0;
  endtask
  // parity bit that makes the one count match the mode
  function automatic logic parOf(input logic [8:0] d, input int nb, input logic [1:0] par);
    logic p;
    p = par[0];
    for (int i = 0; i < nb; i++) p ^= d[i];
    return p;
  endfunction
  // catch one frame on txd and compare it with the loaded character
  task automatic txFrame(input logic [8:0] d);
    int nb;
    logic [8:0] got;
    logic pb;
    logic [1:0] st;
    bit ok;
    nb = 7 + int'(cfg.dataLen);
    far_u.recv(got, pb, st, ok, nb, cfg.parity[1], cfg.stopTwo);
    chk("start", 9'h1, 9'(ok));
    chk("data", d & (9'h1ff >> (9 - nb)), got);
    if (cfg.parity[1]) chk("parity", 9'(parOf(d, nb, cfg.parity)), 9'(pb));
    chk("stops", 9'h3, 9'(st));
  endtask
  initial begin
    rst = 1'b1;
    fracTick = 1'b1;
    txLoad = 1'b0;
    rxTake = 1'b0;
    sclkIn = 1'b0;
    txData = '0;
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.brgReload = 16'h0001;
    evtSeen = '0;
    badCount = 0;
    nChecks = 0;
    void'($urandom(22477));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("idle", 9'h180, {txd, txRdy, rxRdy, rtsN, sclkOut, rxBreak, 3'h0});
    chk("evt", 9'h0, 9'(evt));
    // every length and parity, two characters back to back
    for (int i = 0; i < 9; i++) begin
      cfg.dataLen = 2'(i % 3);
      cfg.parity = PARTAB[i / 3];
      cfg.stopTwo = 1'($urandom);
      d0 = 9'($urandom);
      d1 = (i == 8) ? 9'h1ff : 9'($urandom);
      fork
        txFrame(d0);
        begin
          load(d0);
          load(d1);
        end
      join
      txFrame(d1);
    end
    // receive every format, one bad parity, address marks in 9-bit mode
    for (int i = 0; i < 9; i++) begin
      cfg.dataLen = 2'(i % 3);
      cfg.parity = PARTAB[i / 3];
      cfg.addrMode = (i % 3 == 2);
      cfg.stopTwo = 1'($urandom);
      d0 = 9'($urandom) & (9'h1ff >> (2 - i % 3));
      far_u.send(d0, 7 + i % 3, cfg.parity, cfg.stopTwo, i == 7);
      waitHi("rxRdy", rxRdy);
      chk("rxData", d0, rxWord.data);
      chk("rxErr", 9'((i == 7) ? 2'h2 : 2'h0), 9'({rxWord.noise, rxWord.parErr, rxWord.frameErr}));
      chk("isAddr", 9'(cfg.addrMode & d0[8]), 9'(rxWord.isAddr));
      take();
      chk("rxTake", 9'h0, 9'(rxRdy));
    end
    // second character into a full buffer is dropped
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.brgReload = 16'h0001;
    cfg.dataLen = `USAS_LEN8;
    cfg.ctsEn = 1'b1;
    evtSeen = '0;
    far_u.send(9'h0a5, 8, 2'h0, 1'b0, 1'b0);
    far_u.send(9'h05a, 8, 2'h0, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk("overrun", 9'h1, 9'(evtSeen.overrun));
    chk("kept", 9'h0a5, rxWord.data);
    chk("rtsFull", 9'h1, 9'(rtsN));
    take();
    repeat (2) @(negedge clk);
    chk("rtsFree", 9'h0, 9'(rtsN));
    // incoming break, then its end
    evtSeen = '0;
    far_u.sendBreak(12);
    chk("brk", 9'h4, 9'({rxBreak, rxRdy, rxIdle}));
    chk("brkEvt", 9'h3, 9'({evtSeen.deltaBrk, evtSeen.frameErr}));
    repeat (2 * BITCYC) @(negedge clk);
    chk("brkEnd", 9'h1, 9'({rxBreak, rxIdle}));
    cfg.txBreak = 1'b1;
    repeat (3) @(negedge clk);
    chk("txBreak", 9'h0, 9'(txd));
    cfg.txBreak = 1'b0;
    repeat (3 * BITCYC) @(negedge clk);
    // start held off by clear to send, then by transmit disable
    for (int k = 0; k < 2; k++) begin
      cfg.ctsEn = (k == 0);
      cfg.txDisable = (k == 1);
      evtSeen = '0;
      far_u.setCts(k == 0);
      repeat (3) @(negedge clk);
      d0 = 9'($urandom) & 9'h0ff;
      load(d0);
      repeat (4 * BITCYC) @(negedge clk);
      chk("held", 9'h2, 9'({txd, txRdy}));
      if (k == 0) chk("dCts", 9'h1, 9'(evtSeen.deltaCts));
      fork
        txFrame(d0);
        begin
          cfg.txDisable = 1'b0;
          far_u.setCts(1'b0);
        end
      join
    end
    // data loopback, then flow loopback overriding a stopped far end
    cfg.loopData = 1'b1;
    d0 = 9'($urandom) & 9'h0ff;
    load(d0);
    waitHi("rxRdy", rxRdy);
    chk("loopData", d0, rxWord.data);
    take();
    cfg.loopData = 1'b0;
    cfg.ctsEn = 1'b1;
    cfg.loopFlow = 1'b1;
    far_u.setCts(1'b1);
    d1 = 9'($urandom) & 9'h0ff;
    fork
      txFrame(d1);
      load(d1);
    join
    cfg.loopFlow = 1'b0;
    cfg.ctsEn = 1'b0;
    far_u.setCts(1'b0);
    // synchronous master drives the clock only while working
    cfg.syncEn = 1'b1;
    cfg.syncMaster = 1'b1;
    @(negedge clk);
    chk("sclkOe", 9'h1, 9'(sclkOe));
    load(d0);
    waitHi("sclkOut", sclkOut);
    repeat (300) @(negedge clk);
    cfg.syncMaster = 1'b0;
    evtSeen = '0;
    for (int k = 0; k < 8; k++) begin
      sclkIn = ~sclkIn;
      repeat (4) @(negedge clk);
    end
    chk("underrun", 9'h1, 9'(evtSeen.underrun));
    cfg.syncEn = 1'b0;
    repeat (4) @(negedge clk);
    chk("sclkIdle", 9'h0, 9'(sclkOut));
    endOfTest();
  end
endmodule // usas_top_tb
